// ---- core/pea_avg8.sv ----
`timescale 1ns/1ps
module pea_avg8
  import pea_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                load,
  input  wire logic [SAMPLE_W-1:0] sample,
  output logic      [SAMPLE_W-1:0] avg
);

  logic [SAMPLE_W-1:0]  hist [AVG_DEPTH];
  logic [AVG_PTR_W-1:0] ptr;
  logic [AVG_SUM_W-1:0] sum;
  logic [AVG_SUM_W-1:0] next_sum;

  // Running sum swaps the oldest entry for the newest, so no adder tree is needed.
  always_comb begin
    next_sum = sum + {{AVG_PTR_W{sample[SAMPLE_W-1]}}, sample}
                   - {{AVG_PTR_W{hist[ptr][SAMPLE_W-1]}}, hist[ptr]};
  end

  // History starts at zero, so the mean is only meaningful after eight loads.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < AVG_DEPTH; i++) begin
        hist[i] <= '0;
      end
      ptr <= '0;
      sum <= '0;
    end else if (load) begin
      hist[ptr] <= sample;
      ptr       <= ptr + 3'h1;
      sum       <= next_sum;
    end
  end

  // Arithmetic shift keeps the sign of a bipolar mean.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avg <= '0;
    end else if (load) begin
      avg <= SAMPLE_W'($signed(next_sum) >>> AVG_SHIFT);
    end
  end

endmodule

// ---- core/pea_core.sv ----
`timescale 1ns/1ps
// Operation
// - Rolling eight-sample mean per channel, each conversion.
// - Readable results change only on snapshot commands and enabled slow-pin edges.
// - Averages valid after eight conversions from reset.
// - Permute position cycles through four per conversion.
// - Samples held internally as 17-bit signed.
// - Per-channel unipolar or bipolar result format.
// - 56-bit accumulator, 32-bit counter per channel.
// - Power is 30-bit signed shunt times bus.
// - Every conversion accumulates power and counts sample.
// - Full scale 2^29 when any input bipolar.
// - Adaptive slow mode: shift seven, count 128.
// - Adaptive mode default; slow-edge snapshot disabled.
// - Lower programmed rates scale to mimic 1024.
// - Energy accumulator saturates, never wraps.
// - Sample counter wraps freely on overflow.
// - Full snapshot clears accumulators and counter.
// - Slow pin high forces 8 samples per second.
module pea_core
  import pea_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    cfg_load,
  input  wire pea_cfg_t                cfg_in,
  input  wire logic                    conv_valid,
  input  wire pea_conv_t               conv,
  input  wire logic                    cmd_refresh,
  input  wire logic                    cmd_refresh_v,
  input  wire logic                    cmd_refresh_g,
  input  wire logic                    slow_pin,
  output pea_cfg_t                     cfg,
  output pea_result_t [NCH-1:0]        result,
  output logic        [NCH*PERM_W-1:0] perm_pos,
  output logic        [1:0]            eff_rate,
  output logic                         slow_state,
  output logic                         snapshot_done
);

  // Per-channel live state, invisible to the host until a snapshot.
  logic [SAMPLE_W-1:0] live_bus   [NCH];
  logic [SAMPLE_W-1:0] live_shunt [NCH];
  logic [POWER_W-1:0]  live_power [NCH];
  logic [ACC_W-1:0]    acc        [NCH];
  logic [COUNT_W-1:0]  count      [NCH];
  logic [SAMPLE_W-1:0] avg_bus    [NCH];
  logic [SAMPLE_W-1:0] avg_shunt  [NCH];
  logic [NCH-1:0]      chan_hit;

  logic                slow_q;
  logic                slow_rise;
  logic                slow_fall;
  logic                slow_snap;
  logic                snap_any;
  logic                snap_clear;
  logic [2:0]          acc_shift;
  logic [COUNT_W-1:0]  count_inc;
  logic [POWER_W-1:0]  next_power;

  // Configuration sits in the block so that it has a defined value after reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= CFG_RESET;
    end else if (cfg_load) begin
      cfg <= cfg_in;
    end
  end

  // The slow pin is synchronous to clk; its delayed copy gives both edges.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slow_q <= 1'b0;
    end else begin
      slow_q <= slow_pin;
    end
  end

  assign slow_rise = slow_pin & ~slow_q;
  assign slow_fall = ~slow_pin & slow_q;

  // An edge snapshot only happens when software has enabled it for that edge.
  assign slow_snap = (slow_rise & cfg.slow_rise_en) | (slow_fall & cfg.slow_fall_en);

  // Every command type and enabled pin edge copies results; the plain and general commands clear, and so does a pin edge when slow_full is set.
  assign snap_any   = cmd_refresh | cmd_refresh_v | cmd_refresh_g | slow_snap;
  assign snap_clear = cmd_refresh | cmd_refresh_g | (slow_snap & cfg.slow_full);

  // The sequencer paces conversions from this code; the pin overrides any programmed rate.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eff_rate <= RATE_1024;
    end else begin
      eff_rate <= slow_pin ? RATE_8 : cfg.rate;
    end
  end

  // Pin state for the host, one cycle behind the pin like the edge detector.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slow_state <= 1'b0;
    end else begin
      slow_state <= slow_pin;
    end
  end

  // Adaptive scaling makes every accumulated sample look like one taken at
  // 1024 samples per second, so the host needs no record of rate changes.
  always_comb begin
    acc_shift = SHIFT_1024;
    if (cfg.adaptive) begin
      if (slow_pin) begin
        acc_shift = SHIFT_8;
      end else begin
        case (cfg.rate)
          RATE_256: acc_shift = SHIFT_256;
          RATE_64:  acc_shift = SHIFT_64;
          RATE_8:   acc_shift = SHIFT_8;
          default:  acc_shift = SHIFT_1024;
        endcase
      end
    end
  end

  // The counter grows by the same power of two that scales the data.
  assign count_inc = COUNT_ONE << acc_shift;

  // Product of the full signed shunt value and the top of the bus value.
  always_comb begin
    logic signed [SAMPLE_W+BUS_OP_W-1:0] prod;
    prod       = '0;
    prod       = $signed(conv.shunt) * $signed(conv.bus[SAMPLE_W-1:BUS_OP_LSB]);
    next_power = prod[POWER_W-1:0];
  end

  // Saturating add of a scaled product into a signed accumulator.
  function automatic logic [ACC_W-1:0] sat_add(input logic [ACC_W-1:0]   base,
                                               input logic [POWER_W-1:0] pwr,
                                               input logic [2:0]         sh);
    logic [ACC_W:0] ext;
    logic [ACC_W:0] sum;
    ext = {{(ACC_W+1-POWER_W){pwr[POWER_W-1]}}, pwr} << sh;
    sum = {base[ACC_W-1], base} + ext;
    if (sum[ACC_W] != sum[ACC_W-1]) begin
      sat_add = sum[ACC_W] ? ACC_MIN : ACC_MAX;
    end else begin
      sat_add = sum[ACC_W-1:0];
    end
    return sat_add;
  endfunction

  // Unipolar export drops the sign and clamps negatives; bipolar drops the extra LSB.
  function automatic logic [REPORT_W-1:0] fmt(input logic [SAMPLE_W-1:0] s,
                                              input logic                bipolar);
    if (bipolar) begin
      fmt = s[SAMPLE_W-1:1];
    end else if (s[SAMPLE_W-1]) begin
      fmt = '0;
    end else begin
      fmt = s[REPORT_W-1:0];
    end
    return fmt;
  endfunction

  // Every channel owns its live values, totals, averages and host copy.
  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      logic [PERM_W-1:0] perm;

      // A conversion belongs to this channel only while the strobe stands.
      assign chan_hit[ch] = conv_valid && (conv.chan == CH_W'(ch));

      // Latest single-sample values, kept at full 17-bit signed width.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          live_bus[ch]   <= '0;
          live_shunt[ch] <= '0;
        end else if (chan_hit[ch]) begin
          live_bus[ch]   <= conv.bus;
          live_shunt[ch] <= conv.shunt;
        end
      end

      // Latest power product; it goes to the host untouched by adaptive scaling.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          live_power[ch] <= '0;
        end else if (chan_hit[ch]) begin
          live_power[ch] <= next_power;
        end
      end

      // A sample landing with a clearing snapshot starts the new period,
      // so no conversion is lost across the clear.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          acc[ch] <= '0;
        end else if (snap_clear) begin
          acc[ch] <= chan_hit[ch] ? sat_add('0, next_power, acc_shift) : '0;
        end else if (chan_hit[ch]) begin
          acc[ch] <= sat_add(acc[ch], next_power, acc_shift);
        end
      end

      // The counter follows the same clear rule but wraps instead of saturating.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          count[ch] <= '0;
        end else if (snap_clear) begin
          count[ch] <= chan_hit[ch] ? count_inc : '0;
        end else if (chan_hit[ch]) begin
          count[ch] <= count[ch] + count_inc;
        end
      end

      // The four permute positions are visited in order, one per conversion.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          perm <= '0;
        end else if (chan_hit[ch]) begin
          perm <= perm + 2'h1;
        end
      end

      // The pin copy trails the position counter by one cycle.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          perm_pos[ch*PERM_W +: PERM_W] <= '0;
        end else begin
          perm_pos[ch*PERM_W +: PERM_W] <= perm;
        end
      end

      // Bus voltage mean over the last eight conversions of this channel.
      pea_avg8 u_avg_bus (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (chan_hit[ch]),
        .sample  (conv.bus),
        .avg     (avg_bus[ch])
      );

      // Shunt voltage mean, loaded by the same strobe as the bus mean.
      pea_avg8 u_avg_shunt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (chan_hit[ch]),
        .sample  (conv.shunt),
        .avg     (avg_shunt[ch])
      );

      // Host copy moves only on a snapshot, so a read never sees a value
      // that a conversion is halfway through replacing.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          result[ch].bus   <= '0;
          result[ch].shunt <= '0;
        end else if (snap_any) begin
          result[ch].bus   <= fmt(live_bus[ch], cfg.bus_bipolar[ch]);
          result[ch].shunt <= fmt(live_shunt[ch], cfg.shunt_bipolar[ch]);
        end
      end

      // Averages before the eighth conversion after reset still include
      // the zeroed history; the host must discard them.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          result[ch].bus_avg   <= '0;
          result[ch].shunt_avg <= '0;
        end else if (snap_any) begin
          result[ch].bus_avg   <= fmt(avg_bus[ch], cfg.bus_bipolar[ch]);
          result[ch].shunt_avg <= fmt(avg_shunt[ch], cfg.shunt_bipolar[ch]);
        end
      end

      // Power and totals are copied as raw two's complement; the host
      // divides by the scale that the flag below reports.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          result[ch].power  <= '0;
          result[ch].energy <= '0;
          result[ch].count  <= '0;
        end else if (snap_any) begin
          result[ch].power  <= live_power[ch];
          result[ch].energy <= acc[ch];
          result[ch].count  <= count[ch];
        end
      end

      // Either bipolar input halves the power full scale.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          result[ch].bipolar_scale <= 1'b0;
        end else if (snap_any) begin
          result[ch].bipolar_scale <= cfg.bus_bipolar[ch] | cfg.shunt_bipolar[ch];
        end
      end
    end
  endgenerate

  // One-cycle pulse after the result copy has been written.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snapshot_done <= 1'b0;
    end else begin
      snapshot_done <= snap_any;
    end
  end

endmodule

// ---- core/pea_pkg.sv ----
package pea_pkg;

  // Channel count and datapath widths.
  localparam int NCH         = 4;
  localparam int CH_W        = 2;
  localparam int SAMPLE_W    = 17;
  localparam int REPORT_W    = 16;
  localparam int BUS_OP_W    = 14;
  localparam int POWER_W     = 30;
  localparam int ACC_W       = 56;
  localparam int COUNT_W     = 32;
  localparam int PERM_W      = 2;

  // Rolling average depth and its divide shift.
  localparam int AVG_DEPTH   = 8;
  localparam int AVG_PTR_W   = 3;
  localparam int AVG_SUM_W   = SAMPLE_W + AVG_PTR_W;
  localparam int AVG_SHIFT   = 3;

  // Bit position of the 14 operand bits taken from the signed bus sample.
  localparam int BUS_OP_LSB  = SAMPLE_W - BUS_OP_W;

  // Programmable sample rate codes.
  localparam logic [1:0] RATE_1024 = 2'h0;
  localparam logic [1:0] RATE_256  = 2'h1;
  localparam logic [1:0] RATE_64   = 2'h2;
  localparam logic [1:0] RATE_8    = 2'h3;

  // Adaptive shifts that scale each rate up to 1024 samples per second.
  localparam logic [2:0] SHIFT_1024 = 3'h0;
  localparam logic [2:0] SHIFT_256  = 3'h2;
  localparam logic [2:0] SHIFT_64   = 3'h4;
  localparam logic [2:0] SHIFT_8    = 3'h7;

  // Saturation limits of the signed energy accumulator.
  localparam logic [ACC_W-1:0] ACC_MAX = 56'h7FFFFFFFFFFFFF;
  localparam logic [ACC_W-1:0] ACC_MIN = 56'h80000000000000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h00000001;

  // Configuration held by the block.
  typedef struct packed {
    logic            adaptive;
    logic [1:0]      rate;
    logic            slow_rise_en;
    logic            slow_fall_en;
    logic            slow_full;
    logic [NCH-1:0]  bus_bipolar;
    logic [NCH-1:0]  shunt_bipolar;
  } pea_cfg_t;

  localparam pea_cfg_t CFG_RESET = '{adaptive: 1'b1, rate: RATE_1024, slow_rise_en: 1'b0,
                                     slow_fall_en: 1'b0, slow_full: 1'b1,
                                     bus_bipolar: 4'h0, shunt_bipolar: 4'h0};

  // One conversion result from the ADC sequencer.
  typedef struct packed {
    logic [CH_W-1:0]     chan;
    logic [SAMPLE_W-1:0] bus;
    logic [SAMPLE_W-1:0] shunt;
  } pea_conv_t;

  // Host readable snapshot of one channel.
  typedef struct packed {
    logic [REPORT_W-1:0] bus;
    logic [REPORT_W-1:0] shunt;
    logic [REPORT_W-1:0] bus_avg;
    logic [REPORT_W-1:0] shunt_avg;
    logic [POWER_W-1:0]  power;
    logic [ACC_W-1:0]    energy;
    logic [COUNT_W-1:0]  count;
    logic                bipolar_scale;
  } pea_result_t;

endpackage

// ---- testbench/pea_adc_model.sv ----
`timescale 1ns/1ps
// Stands in for the conversion sequencer that feeds the core.
module pea_adc_model
  import pea_pkg::*;
(
  input  wire logic clk,
  output logic      conv_valid,
  output pea_conv_t conv
);
  initial begin
    conv_valid = 1'b0;
    conv       = '0;
  end
  // One result per call; afterwards the data lines show the inverse so stale data is never trusted.
  task automatic send(input logic [1:0] ch, input logic [16:0] b, input logic [16:0] s);
    @(posedge clk) #1;
    conv_valid = 1'b1;
    conv       = '{chan: ch, bus: b, shunt: s};
    @(posedge clk) #1;
    conv_valid = 1'b0;
    conv       = ~conv;
  endtask
endmodule

// ---- testbench/pea_core_sva.sv ----
`timescale 1ns/1ps
// Pin-level watcher of the accumulator core; it only observes.
module pea_core_sva
  import pea_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  cfg_load,
  input wire pea_cfg_t              cfg_in,
  input wire logic                  conv_valid,
  input wire pea_conv_t             conv,
  input wire logic                  cmd_refresh,
  input wire logic                  cmd_refresh_v,
  input wire logic                  cmd_refresh_g,
  input wire logic                  slow_pin,
  input wire pea_cfg_t              cfg,
  input wire pea_result_t [NCH-1:0] result,
  input wire logic [NCH*PERM_W-1:0] perm_pos,
  input wire logic [1:0]            eff_rate,
  input wire logic                  slow_state,
  input wire logic                  snapshot_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // A clearing snapshot, a quiet cycle, then a copy of the cleared totals.
  sequence seq_clear_copy;
    (cmd_refresh || cmd_refresh_g) && !conv_valid ##1 !conv_valid ##1 cmd_refresh_v;
  endsequence
  // A copy-only snapshot with no conversion and no pin edge beside it.
  sequence seq_copy_only;
    cmd_refresh_v && !cmd_refresh && !cmd_refresh_g && !conv_valid && slow_pin == slow_state;
  endsequence
  // A pin edge that the configuration has enabled for a snapshot.
  sequence seq_slow_edge;
    slow_pin != slow_state && (slow_pin ? cfg.slow_rise_en : cfg.slow_fall_en);
  endsequence

  AST_SNAP_DONE: assert property ((cmd_refresh || cmd_refresh_v || cmd_refresh_g) |=> snapshot_done)
    else $error("snapshot done missing after command");
  AST_RESULT_HOLD: assert property (!$past(sys_rst) && !snapshot_done |-> $stable(result))
    else $error("results changed without a snapshot");
  AST_EFF_RATE: assert property (!$past(sys_rst) |-> eff_rate == ($past(slow_pin) ? 2'h3 : $past(cfg.rate)))
    else $error("effective rate wrong");
  AST_PERM: assert property (conv_valid && conv.chan == 2'h0 |-> ##2 perm_pos[1:0] == $past(perm_pos[1:0]) + 2'h1)
    else $error("permute position did not advance");
  AST_CFG_RESET: assert property ($fell(sys_rst) |-> cfg == CFG_RESET)
    else $error("configuration reset value wrong");
  AST_CFG_LOAD: assert property (cfg_load |=> cfg == $past(cfg_in))
    else $error("configuration not loaded");
  AST_CLEAR: assert property (seq_clear_copy |=> result[0].count == '0 && result[3].energy == '0)
    else $error("totals not cleared");
  AST_NOCLEAR: assert property (seq_copy_only ##1 seq_copy_only |=> result[0].energy == $past(result[0].energy))
    else $error("copy-only snapshot disturbed the totals");
  AST_SLOW_STATE: assert property (!$past(sys_rst) |-> slow_state == $past(slow_pin))
    else $error("slow pin state not tracked");
  AST_SLOW_EDGE: assert property (seq_slow_edge |=> snapshot_done)
    else $error("enabled pin edge gave no snapshot");
endmodule

bind pea_core pea_core_sva chk (
  .clk(clk), .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
  .conv_valid(conv_valid), .conv(conv), .cmd_refresh(cmd_refresh), .cmd_refresh_v(cmd_refresh_v),
  .cmd_refresh_g(cmd_refresh_g), .slow_pin(slow_pin), .cfg(cfg), .result(result),
  .perm_pos(perm_pos), .eff_rate(eff_rate), .slow_state(slow_state), .snapshot_done(snapshot_done)
);

// ---- testbench/test_power_energy_accumulator.sv ----
`timescale 1ns/1ps
module test_power_energy_accumulator;
  import pea_pkg::*;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  cfg_load = 1'b0;
  pea_cfg_t              cfg_in = CFG_RESET;
  logic [2:0]            cmds = 3'h0;
  logic                  slow_pin = 1'b0;
  logic                  conv_valid;
  pea_conv_t             conv;
  pea_cfg_t              cfg;
  pea_result_t [NCH-1:0] result;
  logic [1:0]            eff_rate;
  logic                  snapshot_done;
  int                    err_count = 0;
  int                    checks_done = 0;

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  pea_adc_model adc (.clk(clk), .conv_valid(conv_valid), .conv(conv));

  pea_core uut (
    .clk(clk), .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_in(cfg_in), .conv_valid(conv_valid),
    .conv(conv), .cmd_refresh(cmds[2]), .cmd_refresh_v(cmds[1]), .cmd_refresh_g(cmds[0]),
    .slow_pin(slow_pin), .cfg(cfg), .result(result), .perm_pos(), .eff_rate(eff_rate),
    .slow_state(), .snapshot_done(snapshot_done)
  );

  task automatic final_report();
    $display("errors %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Expected sign-extended product of the shunt value and the top bus bits.
  function automatic logic [55:0] pw(input logic [16:0] b, input logic [16:0] s);
    logic signed [30:0] p;
    p = $signed(s) * $signed(b[16:3]);
    return 56'($signed(p[29:0]));
  endfunction

  // Snapshot command k (0 clearing, 1 copy only, 2 clearing variant) held n cycles.
  task automatic pulse(input int k, input int n);
    @(posedge clk) #1;
    cmds = 3'h4 >> k;
    repeat (n) @(posedge clk);
    #1;
    cmds = 3'h0;
    check(snapshot_done, 1'b1, "snapshot done");
  endtask

  task automatic set_cfg(input pea_cfg_t c);
    @(posedge clk) #1;
    cfg_in = c;
    cfg_load = 1'b1;
    @(posedge clk) #1;
    cfg_load = 1'b0;
    check(cfg, c, "config");
  endtask

  task automatic t_reset();
    check(cfg, CFG_RESET, "reset config");
    check(result[0].count, 0, "reset count");
  endtask

  // Three samples on one channel, one idle cycle apart; totals appear only after the copy.
  task automatic t_accum();
    logic [55:0] e;
    logic [16:0] b;
    logic [16:0] s;
    e = '0;
    pulse(0, 1);
    for (int i = 1; i < 4; i++) begin
      b = 17'h08000 + 17'(i * 'h100);
      s = 17'(i * 'h1000);
      adc.send(2'h0, b, s);
      e = e + pw(b, s);
    end
    check(result[0].energy, 0, "no snapshot yet");
    pulse(1, 2);
    check(result[0].energy, e, "energy sum");
    check(result[0].count, 3, "sample count");
    check(result[0].power, pw(b, s) & 56'h3FFFFFFF, "power product");
    check(result[0].bus, b[15:0], "bus report");
  endtask

  // Nine samples so the oldest one must drop out of the mean.
  task automatic t_avg();
    pea_cfg_t    c;
    logic [16:0] a;
    int          sb;
    int          ss;
    c = CFG_RESET;
    c.shunt_bipolar = 4'h4;
    set_cfg(c);
    sb = 0;
    ss = 0;
    for (int i = 1; i < 10; i++) begin
      adc.send(2'h2, 17'(64 * i), 17'(-8 * i));
      if (i > 1) begin
        sb += 64 * i;
        ss -= 8 * i;
      end
    end
    pulse(2, 1);
    check(result[2].bus_avg, 16'(sb >>> 3), "bus average");
    a = 17'(ss >>> 3);
    check(result[2].shunt_avg, a[16:1], "signed shunt average");
    a = 17'(-72);
    check(result[2].shunt, a[16:1], "signed shunt");
    check(result[2].bipolar_scale, 1'b1, "bipolar scale");
  endtask

  // Every rate code, the slow pin, and plain mode against the adaptive shift.
  task automatic t_rates();
    pea_cfg_t c;
    int       sh[6] = '{0, 2, 4, 7, 7, 0};
    int       rt[6] = '{0, 1, 2, 3, 0, 3};
    for (int k = 0; k < 6; k++) begin
      c = CFG_RESET;
      c.rate = 2'(rt[k]);
      c.adaptive = (k != 5);
      set_cfg(c);
      slow_pin = (k > 3);
      pulse(0, 1);
      adc.send(2'h3, 17'h0A000, 17'h1FF00);
      pulse(1, 1);
      check(result[3].energy, 56'(pw(17'h0A000, 17'h1FF00) << sh[k]), "scaled energy");
      check(result[3].count, 1 << sh[k], "scaled count");
      check(eff_rate, k > 3 ? 3 : rt[k], "effective rate");
      check(result[3].shunt, 0, "unipolar clamp");
    end
    slow_pin = 1'b0;
    pulse(2, 1);
    pulse(1, 1);
    check(result[3].count, 0, "cleared count");
  endtask

  // Pin edges snapshot once enabled: a copy-only rise, then a clearing fall.
  task automatic t_slow();
    pea_cfg_t c;
    c = CFG_RESET;
    c.slow_rise_en = 1'b1;
    c.slow_fall_en = 1'b1;
    c.slow_full    = 1'b0;
    c.bus_bipolar  = 4'h2;
    set_cfg(c);
    adc.send(2'h1, 17'h1C000, 17'h00800);
    slow_pin = 1'b1;
    @(posedge clk) #1;
    check(snapshot_done, 1'b1, "rise snapshot");
    check(result[1].count, 1, "rise copy");
    check(result[1].bus, 16'hE000, "bipolar bus");
    check(result[1].bipolar_scale, 1'b1, "bus bipolar scale");
    c.slow_full = 1'b1;
    set_cfg(c);
    slow_pin = 1'b0;
    @(posedge clk) #1;
    check(result[1].count, 1, "rise kept totals");
    pulse(1, 1);
    check(result[1].count, 0, "fall cleared totals");
  endtask

  // Main sequence: six cycles of reset, then the scenarios.
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_accum();
    t_avg();
    t_rates();
    t_slow();
    final_report();
  end

  // Watchdog well beyond the hundred or so cycles the scenarios need.
  initial begin
    #(5000 * 50);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
